// *** hdl/qtc_top.sv ***
// Decided for this implementation: the placing of the registers and the AHB-Lite interface to the registers.
`default_nettype none
module qtc_top
    import qtc_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    input wire logic [QTC_TEMP_W-1:0] i_die_temp,
    input wire logic i_die_temp_valid,
    output logic [QTC_CODE_W-1:0] o_mod_code,
    output logic [QTC_CODE_W-1:0] o_bias_code,
    output logic [QTC_CODE_W-1:0] o_mon_code
);
    // ==========================================================
    // bus state
    logic wr_pend_reg;
    logic rd_wait_reg;
    logic [7:0] addr_reg;
    logic take;
    logic [31:0] rd_mux;

    // configuration and inputs
    logic src_sel_reg;
    logic [QTC_TEMP_W-1:0] nom_temp_reg;
    logic [QTC_TEMP_W-1:0] host_temp_reg;
    logic [QTC_TEMP_W-1:0] die_temp_reg;
    logic [QTC_COEF_W-1:0] mod_lin_reg;
    logic [QTC_COEF_W-1:0] mod_sq_reg;
    logic [QTC_COEF_W-1:0] bias_lin_reg;
    logic [QTC_COEF_W-1:0] bias_sq_reg;
    logic [QTC_COEF_W-1:0] mon_lin_reg;
    logic [QTC_COEF_W-1:0] mon_sq_reg;
    logic [QTC_CODE_W-1:0] mod_nom_reg;
    logic [QTC_CODE_W-1:0] bias_nom_reg;
    logic [QTC_CODE_W-1:0] mon_nom_reg;

    // datapath
    logic [QTC_TEMP_W-1:0] cur_temp;
    logic signed [10:0] delta;
    logic mod_sat;
    logic bias_sat;
    logic mon_sat;

    // ==========================================================
    // ahb-lite slave: writes have no wait state, reads take one so that
    // a read right behind a write to the same word sees the new value
    assign take = i_hsel && i_htrans[1] && i_hready;
    assign o_hreadyout = ~rd_wait_reg;
    assign o_hresp = 1'b0;

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            wr_pend_reg <= 1'b0;
            rd_wait_reg <= 1'b0;
            addr_reg <= 8'h00;
        end else begin
            if (i_hready) begin
                wr_pend_reg <= take && i_hwrite;
                rd_wait_reg <= take && !i_hwrite;
                if (take) begin
                    addr_reg <= {i_haddr[7:2], 2'b00};
                end
            end else begin
                rd_wait_reg <= 1'b0;
            end
        end
    end

    // upper address bits outside the window alias into it; unmapped reads give zero
    always_comb begin
        rd_mux = QTC_RDATA_RST;
        case (addr_reg)
            QTC_CTRL_OFS: rd_mux[QTC_SRC_SEL_BIT] = src_sel_reg;
            QTC_NOM_TEMP_OFS: rd_mux[QTC_TEMP_W-1:0] = nom_temp_reg;
            QTC_HOST_TEMP_OFS: rd_mux[QTC_TEMP_W-1:0] = host_temp_reg;
            QTC_MOD_COEF_OFS: rd_mux[15:0] = {mod_sq_reg, mod_lin_reg};
            QTC_BIAS_COEF_OFS: rd_mux[15:0] = {bias_sq_reg, bias_lin_reg};
            QTC_MON_COEF_OFS: rd_mux[15:0] = {mon_sq_reg, mon_lin_reg};
            QTC_MOD_NOM_OFS: rd_mux[QTC_CODE_W-1:0] = mod_nom_reg;
            QTC_BIAS_NOM_OFS: rd_mux[QTC_CODE_W-1:0] = bias_nom_reg;
            QTC_MON_NOM_OFS: rd_mux[QTC_CODE_W-1:0] = mon_nom_reg;
            QTC_MOD_OUT_OFS: rd_mux[QTC_CODE_W-1:0] = o_mod_code;
            QTC_BIAS_OUT_OFS: rd_mux[QTC_CODE_W-1:0] = o_bias_code;
            QTC_MON_OUT_OFS: rd_mux[QTC_CODE_W-1:0] = o_mon_code;
            QTC_STATUS_OFS: begin
                rd_mux[2:0] = {mon_sat, bias_sat, mod_sat};
                rd_mux[QTC_DELTA_LSB+10:QTC_DELTA_LSB] = delta;
                rd_mux[31:QTC_DELTA_LSB+11] = {5{delta[10]}};
            end
            default: rd_mux = QTC_RDATA_RST;
        endcase
    end

    // read data held in a flop for the whole data phase
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_hrdata <= QTC_RDATA_RST;
        end else if (rd_wait_reg) begin
            o_hrdata <= rd_mux;
        end
    end

    // ==========================================================
    // software-written configuration; output and status words are read only
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            src_sel_reg <= QTC_SRC_SEL_RST;
            nom_temp_reg <= QTC_TEMP_RST;
            host_temp_reg <= QTC_TEMP_RST;
            mod_lin_reg <= QTC_COEF_RST;
            mod_sq_reg <= QTC_COEF_RST;
            bias_lin_reg <= QTC_COEF_RST;
            bias_sq_reg <= QTC_COEF_RST;
            mon_lin_reg <= QTC_COEF_RST;
            mon_sq_reg <= QTC_COEF_RST;
            mod_nom_reg <= QTC_CODE_RST;
            bias_nom_reg <= QTC_CODE_RST;
            mon_nom_reg <= QTC_CODE_RST;
        end else if (wr_pend_reg) begin
            case (addr_reg)
                QTC_CTRL_OFS: src_sel_reg <= i_hwdata[QTC_SRC_SEL_BIT];
                QTC_NOM_TEMP_OFS: nom_temp_reg <= i_hwdata[QTC_TEMP_W-1:0];
                QTC_HOST_TEMP_OFS: host_temp_reg <= i_hwdata[QTC_TEMP_W-1:0];
                QTC_MOD_COEF_OFS: begin
                    mod_lin_reg <= i_hwdata[QTC_COEF_W-1:0];
                    mod_sq_reg <= i_hwdata[QTC_SQ_LSB+QTC_COEF_W-1:QTC_SQ_LSB];
                end
                QTC_BIAS_COEF_OFS: begin
                    bias_lin_reg <= i_hwdata[QTC_COEF_W-1:0];
                    bias_sq_reg <= i_hwdata[QTC_SQ_LSB+QTC_COEF_W-1:QTC_SQ_LSB];
                end
                QTC_MON_COEF_OFS: begin
                    mon_lin_reg <= i_hwdata[QTC_COEF_W-1:0];
                    mon_sq_reg <= i_hwdata[QTC_SQ_LSB+QTC_COEF_W-1:QTC_SQ_LSB];
                end
                QTC_MOD_NOM_OFS: mod_nom_reg <= i_hwdata[QTC_CODE_W-1:0];
                QTC_BIAS_NOM_OFS: bias_nom_reg <= i_hwdata[QTC_CODE_W-1:0];
                QTC_MON_NOM_OFS: mon_nom_reg <= i_hwdata[QTC_CODE_W-1:0];
                default: ;
            endcase
        end
    end

    // ==========================================================
    // die reading kept between conversions so delta never sees a gap
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            die_temp_reg <= QTC_TEMP_RST;
        end else if (i_die_temp_valid) begin
            die_temp_reg <= i_die_temp;
        end
    end

    // unsigned halves of a kelvin, difference carried one bit wider
    always_comb begin
        cur_temp = src_sel_reg ? host_temp_reg : die_temp_reg;
        delta = $signed({1'b0, cur_temp}) - $signed({1'b0, nom_temp_reg});
    end

    // ==========================================================
    // one scaler per quantity, each fed its own pair
    qtc_scale_unit #(
        .W(QTC_CODE_W),
        .CW(QTC_COEF_W)
    ) u_mod (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_nominal(mod_nom_reg),
        .i_delta(delta),
        .i_lin_coef($signed(mod_lin_reg)),
        .i_sq_coef($signed(mod_sq_reg)),
        .o_value(o_mod_code),
        .o_sat(mod_sat)
    );

    qtc_scale_unit #(
        .W(QTC_CODE_W),
        .CW(QTC_COEF_W)
    ) u_bias (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_nominal(bias_nom_reg),
        .i_delta(delta),
        .i_lin_coef($signed(bias_lin_reg)),
        .i_sq_coef($signed(bias_sq_reg)),
        .o_value(o_bias_code),
        .o_sat(bias_sat)
    );

    // log-coded monitor value is scaled as is, not linearised first
    qtc_scale_unit #(
        .W(QTC_CODE_W),
        .CW(QTC_COEF_W)
    ) u_mon (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_nominal(mon_nom_reg),
        .i_delta(delta),
        .i_lin_coef($signed(mon_lin_reg)),
        .i_sq_coef($signed(mon_sq_reg)),
        .o_value(o_mon_code),
        .o_sat(mon_sat)
    );
endmodule
`default_nettype wire

// *** hdl/qtc_pkg.sv ***
// What this block does
// - each nominal code is multiplied by one plus a linear and a square term in delta T.
// - the linear term is coefficient times delta over 2^13, the square term over 2^18.
// - with the source select at 0, delta is the die reading minus the nominal temperature.
// - with the source select at 1, delta is the host value minus the nominal temperature.
// - die, host and nominal temperatures are 10-bit unsigned at half a kelvin per step.
// - every coefficient is an 8-bit two's complement value from -128 to +127.
// - modulation, bias and monitor each use only their own coefficient pair.
// - the factor acts on digital codes, for the monitor on its logarithmic code.
`default_nettype none
package qtc_pkg;
    // ==========================================================
    // widths
    localparam int QTC_TEMP_W = 10;
    localparam int QTC_COEF_W = 8;
    localparam int QTC_CODE_W = 10;
    localparam int QTC_LIN_SHIFT = 13;
    localparam int QTC_SQ_SHIFT = 18;
    // ==========================================================
    // register byte offsets
    localparam logic [7:0] QTC_CTRL_OFS = 8'h00;
    localparam logic [7:0] QTC_NOM_TEMP_OFS = 8'h04;
    localparam logic [7:0] QTC_HOST_TEMP_OFS = 8'h08;
    localparam logic [7:0] QTC_MOD_COEF_OFS = 8'h0C;
    localparam logic [7:0] QTC_BIAS_COEF_OFS = 8'h10;
    localparam logic [7:0] QTC_MON_COEF_OFS = 8'h14;
    localparam logic [7:0] QTC_MOD_NOM_OFS = 8'h18;
    localparam logic [7:0] QTC_BIAS_NOM_OFS = 8'h1C;
    localparam logic [7:0] QTC_MON_NOM_OFS = 8'h20;
    localparam logic [7:0] QTC_MOD_OUT_OFS = 8'h24;
    localparam logic [7:0] QTC_BIAS_OUT_OFS = 8'h28;
    localparam logic [7:0] QTC_MON_OUT_OFS = 8'h2C;
    localparam logic [7:0] QTC_STATUS_OFS = 8'h30;
    // ==========================================================
    // field positions
    localparam int QTC_SRC_SEL_BIT = 0;
    localparam int QTC_SQ_LSB = 8;
    localparam int QTC_DELTA_LSB = 16;
    // ==========================================================
    // values after reset
    localparam logic QTC_SRC_SEL_RST = 1'b0;
    localparam logic [9:0] QTC_TEMP_RST = 10'h000;
    localparam logic [7:0] QTC_COEF_RST = 8'h00;
    localparam logic [9:0] QTC_CODE_RST = 10'h000;
    localparam logic [31:0] QTC_RDATA_RST = 32'h0000_0000;
endpackage
`default_nettype wire

// *** hdl/qtc_scale_unit.sv ***
`default_nettype none
module qtc_scale_unit
    import qtc_pkg::*;
#(
    parameter int W = QTC_CODE_W,
    parameter int CW = QTC_COEF_W
) (
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic [W-1:0] i_nominal,
    input wire logic signed [10:0] i_delta,
    input wire logic signed [CW-1:0] i_lin_coef,
    input wire logic signed [CW-1:0] i_sq_coef,
    output logic [W-1:0] o_value,
    output logic o_sat
);
    localparam int PW = W + 1 + 32;
    localparam logic signed [31:0] ONE_FIX = 32'sh0000_0001 <<< QTC_SQ_SHIFT;
    localparam logic signed [PW-1:0] MAX_CODE = PW'((64'h1 << W) - 64'h1);

    logic signed [21:0] sq;
    logic signed [CW+21:0] sq_term;
    logic signed [CW+10:0] lin_term;
    logic signed [31:0] factor;
    logic signed [PW-1:0] prod;
    logic signed [PW-1:0] scaled;
    logic [W-1:0] value_next;
    logic sat_next;

    // ==========================================================
    // factor in units of 2^-18, linear term aligned by 2^5
    always_comb begin
        sq = i_delta * i_delta;
        sq_term = i_sq_coef * sq;
        lin_term = i_lin_coef * i_delta;
        factor = ONE_FIX + 32'(sq_term)
            + (32'(lin_term) <<< (QTC_SQ_SHIFT - QTC_LIN_SHIFT));
        prod = $signed({1'b0, i_nominal}) * factor;
        scaled = prod >>> QTC_SQ_SHIFT; // floor, so negatives round down
    end

    // clamp to code range; a wrap would slam the current to the far end
    always_comb begin
        if (scaled < 0) begin
            value_next = '0;
            sat_next = 1'b1;
        end else if (scaled > MAX_CODE) begin
            value_next = {W{1'b1}};
            sat_next = 1'b1;
        end else begin
            value_next = scaled[W-1:0];
            sat_next = 1'b0;
        end
    end

    // registered output, one cycle behind its inputs
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_value <= QTC_CODE_RST;
            o_sat <= 1'b0;
        end else begin
            o_value <= value_next;
            o_sat <= sat_next;
        end
    end
endmodule
`default_nettype wire

// *** testbench/qtc_top_props.sv ***
`default_nettype none
module qtc_top_props
    import qtc_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic i_hsel,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic i_hready,
    input wire logic [31:0] o_hrdata,
    input wire logic o_hreadyout,
    input wire logic o_hresp,
    input wire logic i_die_temp_valid,
    input wire logic [QTC_CODE_W-1:0] o_mod_code,
    input wire logic [QTC_CODE_W-1:0] o_bias_code,
    input wire logic [QTC_CODE_W-1:0] o_mon_code
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // bus handshake and code stability
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_sys_rst);
    logic take;
    // transfer accepted this cycle
    assign take = i_hsel && i_htrans[1] && i_hready;
    okay_resp_a: assert property (o_hresp == 1'b0) else $error("bad response");
    read_wait_a: assert property (take && !i_hwrite |=> !o_hreadyout ##1 o_hreadyout)
        else $error("read wait wrong");
    write_nowait_a: assert property (take && i_hwrite |=> o_hreadyout) else $error("write stall");
    wait_single_a: assert property (!o_hreadyout |=> o_hreadyout) else $error("long wait");
    rdata_hold_a: assert property ($changed(o_hrdata) |-> $past(o_hreadyout) == 1'b0)
        else $error("read data moved");
    // a write lands one edge late, its code one more: four quiet edges needed
    codes_idle_a: assert property ((!i_hsel && !i_die_temp_valid)[*4] |-> $stable(o_mod_code)
        && $stable(o_bias_code) && $stable(o_mon_code)) else $error("code moved idle");
    reset_bus_a: assert property ($fell(i_sys_rst) |-> o_hreadyout && o_hrdata == 32'h0)
        else $error("bus not reset");
    reset_codes_a: assert property ($fell(i_sys_rst) |-> o_mod_code == 10'h0
        && o_bias_code == 10'h0 && o_mon_code == 10'h0) else $error("codes not reset");
endmodule
bind qtc_top qtc_top_props qtc_top_props_i (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
    .i_hsel(i_hsel), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hready(i_hready),
    .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
    .i_die_temp_valid(i_die_temp_valid), .o_mod_code(o_mod_code),
    .o_bias_code(o_bias_code), .o_mon_code(o_mon_code));
`default_nettype wire

// *** testbench/qtc_host_model.sv ***
`default_nettype none
module qtc_host_model
    import qtc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_hready,
    input wire logic [31:0] i_hrdata,
    output logic o_hsel,
    output logic [31:0] o_haddr,
    output logic [1:0] o_htrans,
    output logic o_hwrite,
    output logic [31:0] o_hwdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic rdy_s;
    logic [31:0] rd_s;
    // ==========================================
    // bus master
    // mid-cycle capture, so each edge sees the settled answer
    always @(negedge i_clk) begin
        rdy_s = i_hready;
        rd_s = i_hrdata;
    end
    initial begin
        o_hsel = 1'b0;
        o_haddr = 32'h0;
        o_htrans = 2'b00;
        o_hwrite = 1'b0;
        o_hwdata = 32'h0;
    end
    // single word transfer, entered just after a rising edge
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd,
        output logic [31:0] rd);
        o_hsel <= 1'b1;
        o_haddr <= {24'h0, a};
        o_htrans <= 2'b10;
        o_hwrite <= w;
        do @(posedge i_clk); while (rdy_s !== 1'b1);
        o_hsel <= 1'b0;
        o_htrans <= 2'b00;
        o_haddr <= ~{24'h0, a};
        o_hwdata <= wd;
        do @(posedge i_clk); while (rdy_s !== 1'b1);
        rd = rd_s;
        o_hwdata <= ~wd;
    endtask
    // host hands its own temperature reading to the device
    task automatic send_temp(input logic [9:0] t);
        logic [31:0] dummy;
        xfer(QTC_HOST_TEMP_OFS, 1'b1, {22'h0, t}, dummy);
    endtask
endmodule
`default_nettype wire

// *** testbench/testbench.sv ***
`default_nettype none
module testbench
    import qtc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic dv = 1'b0;
    logic hsel, hwrite, hready, hresp;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [9:0] dt = 10'h000;
    logic [9:0] code [3];
    int n_fail = 0;
    int n_compared = 0;
    int seed = 32'hFE1D;
    always #2.5 clk = ~clk;
    qtc_top qtc_top_i (.i_core_clk(clk), .i_sys_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
        .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
        .i_die_temp(dt), .i_die_temp_valid(dv), .o_mod_code(code[0]),
        .o_bias_code(code[1]), .o_mon_code(code[2]));
    qtc_host_model qtc_host_model_i (.i_clk(clk), .i_hready(hready), .i_hrdata(hrdata),
        .o_hsel(hsel), .o_haddr(haddr), .o_htrans(htrans), .o_hwrite(hwrite), .o_hwdata(hwdata));
    // ==========================================
    // helpers
    task automatic report_and_stop();
        if (n_fail == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        qtc_host_model_i.xfer(a, 1'b1, d, r);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        qtc_host_model_i.xfer(a, 1'b0, 32'h0, r);
        check(r, e);
    endtask
    // floor then clamp, so overflow saturates rather than wraps
    function automatic logic [9:0] exp_code(input logic [9:0] n, input logic signed [10:0] d,
        input logic signed [7:0] l, input logic signed [7:0] s);
        longint p;
        p = longint'(n) * (64'sh40000 + longint'(s) * d * d + (longint'(l) * d <<< 5));
        p = p >>> 18;
        return (p < 0) ? 10'h000 : ((p > 64'sh3FF) ? 10'h3FF : p[9:0]);
    endfunction
    // true where the unclamped result leaves the code range
    function automatic logic exp_sat(input logic [9:0] n, input logic signed [10:0] d,
        input logic signed [7:0] l, input logic signed [7:0] s);
        longint p;
        p = longint'(n) * (64'sh40000 + longint'(s) * d * d + (longint'(l) * d <<< 5));
        p = p >>> 18;
        return (p < 0) || (p > 64'sh3FF);
    endfunction
    // ==========================================
    // main sequence
    initial begin
        logic [9:0] tn, th, td;
        logic sel;
        logic [7:0] lc [3];
        logic [7:0] sc [3];
        logic [9:0] nc [3];
        logic signed [10:0] d;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdc(QTC_CTRL_OFS, 32'h0);
        rdc(QTC_NOM_TEMP_OFS, 32'h0);
        wr(QTC_MOD_COEF_OFS, 32'hFFFF_FFFF);
        rdc(QTC_MOD_COEF_OFS, 32'h0000_FFFF);
        wr(QTC_MOD_OUT_OFS, 32'hFFFF_FFFF);
        rdc(QTC_MOD_OUT_OFS, 32'h0);
        wr(8'h3C, 32'hFFFF_FFFF);
        rdc(8'h3C, 32'h0);
        // random settings; the first two drive the factor past both ends
        for (int k = 0; k < 40; k++) begin
            tn = k < 2 ? 10'h000 : 10'($random(seed));
            th = k < 2 ? 10'h3FF : 10'($random(seed));
            td = k < 2 ? 10'h3FF : 10'($random(seed));
            sel = 1'($random(seed));
            for (int c = 0; c < 3; c++) begin
                lc[c] = k < 2 ? (k ? 8'h80 : 8'h7F) : 8'($random(seed));
                sc[c] = k < 2 ? (k ? 8'h00 : 8'h7F) : 8'($random(seed));
                nc[c] = k < 2 ? 10'h3FF : 10'($random(seed));
                wr(8'(QTC_MOD_COEF_OFS + 4 * c), {16'h0, sc[c], lc[c]});
                wr(8'(QTC_MOD_NOM_OFS + 4 * c), {22'h0, nc[c]});
            end
            wr(QTC_CTRL_OFS, {31'h0, sel});
            wr(QTC_NOM_TEMP_OFS, {22'h0, tn});
            qtc_host_model_i.send_temp(th);
            dt <= td;
            dv <= 1'b1;
            @(posedge clk);
            dv <= 1'b0;
            // four quiet edges so the idle-stability property gets exercised
            repeat (4) @(posedge clk);
            #1;
            d = $signed({1'b0, sel ? th : td}) - $signed({1'b0, tn});
            for (int c = 0; c < 3; c++) begin
                check({22'h0, code[c]}, {22'h0, exp_code(nc[c], d, lc[c], sc[c])});
            end
            @(posedge clk);
            rdc(QTC_BIAS_OUT_OFS, {22'h0, exp_code(nc[1], d, lc[1], sc[1])});
            qtc_host_model_i.xfer(QTC_STATUS_OFS, 1'b0, 32'h0, r);
            check({16'h0, r[31:16]}, {16'h0, {5{d[10]}}, d});
            // live saturation flags, one per quantity
            for (int c = 0; c < 3; c++) begin
                check({31'h0, r[c]}, {31'h0, exp_sat(nc[c], d, lc[c], sc[c])});
            end
            rdc(QTC_HOST_TEMP_OFS, {22'h0, th});
        end
        // second reset in mid-run
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdc(QTC_CTRL_OFS, 32'h0);
        rdc(QTC_MOD_OUT_OFS, 32'h0);
        report_and_stop();
    end
    // hang guard
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        report_and_stop();
    end
endmodule
`default_nettype wire
